/* File: scb_unit.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE1 - Nibble exchange writes the memory byte back with its two halves swapped and leaves the accumulator alone.
// RULE2 - Compare-skip subtracts the operand from the accumulator, keeps no difference, updates zero and carry, skips on equal.
// RULE3 - Low-bank bit clear forces the addressed bit of the bank-0 location to 0 whatever bank is selected.
// RULE4 - Low-bank bit set forces the addressed bit of the bank-0 location to 1 whatever bank is selected.
// RULE5 - A met skip condition suppresses the next instruction and costs extra cycles beyond the base cycle.
module scb_unit import scb_pkg::*; #(
	parameter int SKIP_LEN = SKIP_CYCLES
) (
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic req_valid_i,
	input wire scb_req_type req_i,
	output var scb_res_type res_o,
	output logic busy_o,
	output logic done_o
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	typedef enum logic {
		ST_RUN,
		ST_SKIP
	} scb_state_type;

	localparam int SKIP_WAIT = SKIP_LEN;
	localparam int CNT_W = $clog2(SKIP_LEN + 1);

	scb_state_type state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	scb_res_type res_q, res_d;
	logic busy_q, busy_d;
	logic done_q, done_d;
	logic take;
	logic [DATA_W-1:0] cmp_operand;
	logic cmp_zero;
	logic cmp_carry;

	// Single-bit mask, shared by both bit operations
	function automatic logic [DATA_W-1:0] bit_mask(input logic [BIT_IDX_W-1:0] idx);
		logic [DATA_W-1:0] m;
		m = '0;
		m[idx] = 1'b1;
		return m;
	endfunction

	// ----------------------------------------
	// Compare path
	// ----------------------------------------
	// Requests are refused while a skip is being paid for
	assign take = req_valid_i && !busy_q;
	assign cmp_operand = (req_i.op == OP_CMP_SKIP_IMM) ? req_i.imm : req_i.mem_data;

	scb_cmp_sub #(
		.WIDTH(DATA_W)
	) u_cmp (
		.minuend_i(req_i.acc),
		.subtrahend_i(cmp_operand),
		.zero_o(cmp_zero),
		.carry_o(cmp_carry)
	);

	// ----------------------------------------
	// Next result
	// ----------------------------------------
	// Flags hold their last value outside compares; strobes are one cycle
	always_comb begin
		res_d = res_q;
		res_d.mem_we = 1'b0;
		res_d.flag_we = 1'b0;
		res_d.skip = 1'b0;
		done_d = 1'b0;
		if (take) begin
			done_d = (req_i.op != OP_NONE);
			case (req_i.op)
				OP_NIBBLE_EXCHANGE: begin
					// No accumulator write port exists, so it cannot change
					res_d.mem_we = 1'b1; // RULE1
					res_d.mem_bank = req_i.bank;
					res_d.mem_offs = req_i.offs;
					res_d.mem_wdata = {req_i.mem_data[NIB_W-1:0], req_i.mem_data[DATA_W-1:NIB_W]}; // RULE1
				end
				OP_CMP_SKIP_IMM, OP_CMP_SKIP_MEM: begin
					// Difference is discarded; only the flags and the skip strobe leave
					res_d.flag_we = 1'b1; // RULE2
					res_d.zero_flag = cmp_zero; // RULE2
					res_d.carry_flag = cmp_carry; // RULE2
					res_d.skip = cmp_zero; // RULE2
				end
				OP_LOW_BANK_BIT_CLEAR: begin
					res_d.mem_we = 1'b1;
					res_d.mem_bank = BANK_ZERO; // RULE3
					res_d.mem_offs = req_i.offs;
					res_d.mem_wdata = req_i.mem_data & ~bit_mask(req_i.bit_idx); // RULE3
				end
				OP_LOW_BANK_BIT_SET: begin
					res_d.mem_we = 1'b1;
					res_d.mem_bank = BANK_ZERO; // RULE4
					res_d.mem_offs = req_i.offs;
					res_d.mem_wdata = req_i.mem_data | bit_mask(req_i.bit_idx); // RULE4
				end
				default: begin
					done_d = 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Skip sequencing
	// ----------------------------------------
	// Busy covers the suppressed slot so the sequencer cannot issue into it
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		busy_d = busy_q;
		case (state_q)
			ST_RUN: begin
				if (take && res_d.skip) begin
					state_d = ST_SKIP; // RULE5
					cnt_d = CNT_W'(SKIP_LEN);
					busy_d = 1'b1; // RULE5
				end
			end
			ST_SKIP: begin
				cnt_d = cnt_q - CNT_W'(1);
				if (cnt_q == CNT_W'(1)) begin
					state_d = ST_RUN;
					busy_d = 1'b0;
				end
			end
			default: begin
				state_d = ST_RUN;
				busy_d = 1'b0;
			end
		endcase
	end

	// Registers only
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			state_q <= ST_RUN;
			cnt_q <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			res_q <= '{mem_we: 1'b0, mem_bank: BANK_ZERO, mem_offs: OFFS_RESET, mem_wdata: DATA_RESET,
				flag_we: 1'b0, zero_flag: 1'b0, carry_flag: 1'b0, skip: 1'b0};
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			busy_q <= busy_d;
			done_q <= done_d;
			res_q <= res_d;
		end
	end

	assign res_o = res_q;
	assign busy_o = busy_q;
	assign done_o = done_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	nibble_swap_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE1
		(take && req_i.op == OP_NIBBLE_EXCHANGE) |=> res_q.mem_we && !res_q.flag_we &&
		res_q.mem_wdata == {$past(req_i.mem_data[NIB_W-1:0]), $past(req_i.mem_data[DATA_W-1:NIB_W])})
		else $error("nibble exchange wrote wrong byte");

	compare_flags_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE2
		(take && req_i.op == OP_CMP_SKIP_IMM) |=> res_q.flag_we && !res_q.mem_we &&
		res_q.zero_flag == ($past(req_i.acc) == $past(req_i.imm)) &&
		res_q.carry_flag == ($past(req_i.acc) >= $past(req_i.imm)))
		else $error("compare flags wrong");

	compare_skip_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE2
		(take && req_i.op == OP_CMP_SKIP_MEM) |=> res_q.skip == ($past(req_i.acc) == $past(req_i.mem_data)))
		else $error("skip disagrees with equality");

	bit_clear_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE3
		(take && req_i.op == OP_LOW_BANK_BIT_CLEAR) |=> res_q.mem_we && res_q.mem_bank == BANK_ZERO &&
		res_q.mem_wdata == ($past(req_i.mem_data) & ~bit_mask($past(req_i.bit_idx))))
		else $error("bit clear wrong");

	bit_set_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE4
		(take && req_i.op == OP_LOW_BANK_BIT_SET) |=> res_q.mem_we && res_q.mem_bank == BANK_ZERO &&
		res_q.mem_wdata == ($past(req_i.mem_data) | bit_mask($past(req_i.bit_idx))))
		else $error("bit set wrong");

	skip_busy_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE5
		res_q.skip |-> busy_q ##[1:SKIP_WAIT] !busy_q)
		else $error("skip slot length wrong");

	skip_refuse_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE5
		(busy_q && req_valid_i) |=> !done_q && !res_q.mem_we && !res_q.flag_we)
		else $error("request taken during skip slot");

	exchange_target_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE1
		(take && req_i.op == OP_NIBBLE_EXCHANGE) |=> res_q.mem_bank == $past(req_i.bank) &&
		res_q.mem_offs == $past(req_i.offs) && !res_q.skip && done_q)
		else $error("nibble exchange target wrong");

	mem_compare_flags_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE2
		(take && req_i.op == OP_CMP_SKIP_MEM) |=> res_q.flag_we && !res_q.mem_we &&
		res_q.zero_flag == ($past(req_i.acc) == $past(req_i.mem_data)) &&
		res_q.carry_flag == ($past(req_i.acc) >= $past(req_i.mem_data)))
		else $error("memory compare flags wrong");

	// Flags must survive every non-compare, or a later skip test would read stale state
	flags_hold_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE2
		!(take && (req_i.op == OP_CMP_SKIP_IMM || req_i.op == OP_CMP_SKIP_MEM)) |=>
		$stable(res_q.zero_flag) && $stable(res_q.carry_flag) && !res_q.flag_we && !res_q.skip)
		else $error("flags moved without a compare");

	bit_target_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE3
		(take && (req_i.op == OP_LOW_BANK_BIT_CLEAR || req_i.op == OP_LOW_BANK_BIT_SET)) |=>
		res_q.mem_offs == $past(req_i.offs) && !res_q.flag_we && !res_q.skip && done_q)
		else $error("bit operation target wrong");

	busy_start_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE5
		$rose(busy_q) |-> res_q.skip && done_q)
		else $error("skip slot opened without a skip");
endmodule
`default_nettype wire

/* File: scb_pkg.sv */
// ----------------------------------------
// Shared types and constants
// ----------------------------------------
package scb_pkg;
	localparam int DATA_W = 8;
	localparam int NIB_W = 4;
	localparam int BANK_W = 1;
	localparam int OFFS_W = 7;
	localparam int BIT_IDX_W = 3;
	localparam int SKIP_CYCLES = 1;
	localparam logic [BANK_W-1:0] BANK_ZERO = 1'h0;
	localparam logic BIT_CLEARED = 1'h0;
	localparam logic BIT_SET = 1'h1;
	localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
	localparam logic [OFFS_W-1:0] OFFS_RESET = 7'h00;

	// Operation select from the decoder
	typedef enum logic [2:0] {
		OP_NONE,
		OP_NIBBLE_EXCHANGE,
		OP_CMP_SKIP_IMM,
		OP_CMP_SKIP_MEM,
		OP_LOW_BANK_BIT_CLEAR,
		OP_LOW_BANK_BIT_SET
	} scb_op_type;

	// Request from the sequencer
	typedef struct packed {
		scb_op_type op;
		logic [DATA_W-1:0] acc;
		logic [DATA_W-1:0] imm;
		logic [DATA_W-1:0] mem_data;
		logic [BANK_W-1:0] bank;
		logic [OFFS_W-1:0] offs;
		logic [BIT_IDX_W-1:0] bit_idx;
	} scb_req_type;

	// Result towards memory, flags and sequencer
	typedef struct packed {
		logic mem_we;
		logic [BANK_W-1:0] mem_bank;
		logic [OFFS_W-1:0] mem_offs;
		logic [DATA_W-1:0] mem_wdata;
		logic flag_we;
		logic zero_flag;
		logic carry_flag;
		logic skip;
	} scb_res_type;
endpackage

/* File: scb_cmp_sub.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Subtract-only comparator
// ----------------------------------------
module scb_cmp_sub import scb_pkg::*; #(
	parameter int WIDTH = DATA_W
) (
	input wire logic [WIDTH-1:0] minuend_i,
	input wire logic [WIDTH-1:0] subtrahend_i,
	output logic zero_o,
	output logic carry_o
);
	logic [WIDTH:0] diff;

	// Extra bit catches the borrow; carry is set when no borrow occurs
	always_comb begin
		diff = {1'b0, minuend_i} - {1'b0, subtrahend_i};
		zero_o = (diff[WIDTH-1:0] == '0);
		carry_o = ~diff[WIDTH];
	end
endmodule
`default_nettype wire

/* File: tb_scb_unit.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Self-checking bench
// ----------------------------------------
module tb_scb_unit import scb_pkg::*;;
	logic mclk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic req_valid_i = 1'b0;
	scb_req_type req_i = '0;
	scb_res_type res_o;
	logic busy_o;
	logic done_o;
	int failures = 0;
	int tests_run = 0;
	int seed = 9244;
	scb_res_type exp_q[$];
	scb_res_type mask_q[$];
	logic [7:0] a;
	logic [7:0] o;

	scb_unit #(.SKIP_LEN(1)) u_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .req_valid_i(req_valid_i),
		.req_i(req_i), .res_o(res_o), .busy_o(busy_o), .done_o(done_o));

	// Clock
	initial begin
		forever #5 mclk_i = ~mclk_i;
	end

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic check_res(input scb_res_type e, input scb_res_type m);
		tests_run++;
		if ((res_o & m) !== (e & m)) begin
			failures++;
			$display("wrong value res_o expected %h seen %h", e & m, res_o & m);
		end
	endtask

	task automatic check_bit(input string name, input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %b seen %b", name, e, g);
		end
	endtask

	// One request; the expected result goes to the queue unless the op is OP_NONE
	task automatic send(input scb_op_type op, input logic [7:0] acc, input logic [7:0] imm,
		input logic [7:0] mem, input logic bank, input logic [6:0] offs, input logic [2:0] bi);
		scb_res_type e;
		scb_res_type m;
		logic [7:0] opnd;
		e = '0;
		m = '0;
		opnd = (op == OP_CMP_SKIP_IMM) ? imm : mem;
		@(negedge mclk_i);
		req_valid_i = 1'b1;
		req_i = '{op, acc, imm, mem, bank, offs, bi};
		case (op)
			OP_NIBBLE_EXCHANGE: begin
				e.mem_wdata = {mem[3:0], mem[7:4]};
				e.mem_bank = bank;
			end
			OP_LOW_BANK_BIT_CLEAR: e.mem_wdata = mem & ~(8'h01 << bi);
			OP_LOW_BANK_BIT_SET: e.mem_wdata = mem | (8'h01 << bi);
			default: begin
				e.zero_flag = (acc == opnd);
				e.carry_flag = (acc >= opnd);
				e.skip = (acc == opnd) && op != OP_NONE;
			end
		endcase
		m.mem_we = 1'b1;
		m.flag_we = 1'b1;
		m.skip = 1'b1;
		if (op inside {OP_CMP_SKIP_IMM, OP_CMP_SKIP_MEM}) begin
			e.flag_we = 1'b1;
			m.zero_flag = 1'b1;
			m.carry_flag = 1'b1;
		end else begin
			e.mem_we = 1'b1;
			e.mem_offs = offs;
			m.mem_bank = '1;
			m.mem_offs = '1;
			m.mem_wdata = '1;
		end
		if (op != OP_NONE) begin
			exp_q.push_back(e);
			mask_q.push_back(m);
		end
		// A request in the skip slot must be dropped
		if (e.skip) begin
			@(negedge mclk_i);
			req_i.op = OP_LOW_BANK_BIT_SET;
			check_bit("busy_o", 1'b1, busy_o);
		end
	endtask

	// Monitor: each done pulse takes the oldest note
	initial begin
		forever begin
			@(posedge mclk_i);
			#1;
			if (reset_n_i && done_o !== 1'b0) begin
				if (exp_q.size() == 0) begin
					failures++;
					$display("wrong value done_o expected 0 seen %b", done_o);
				end else check_res(exp_q.pop_front(), mask_q.pop_front());
			end
		end
	end

	// Watchdog
	initial begin
		repeat (5000) @(posedge mclk_i);
		failures++;
		give_verdict();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge mclk_i);
		@(negedge mclk_i);
		reset_n_i = 1'b1;
		check_bit("res_o idle", 1'b1, res_o === '0);
		check_bit("busy_o", 1'b0, busy_o);
		// Boundaries: equal, borrow, no borrow
		send(OP_CMP_SKIP_IMM, 8'h00, 8'h00, 8'h11, 1'b1, 7'h00, 3'h0);
		send(OP_CMP_SKIP_IMM, 8'h00, 8'hff, 8'h00, 1'b1, 7'h00, 3'h0);
		send(OP_CMP_SKIP_MEM, 8'hff, 8'h00, 8'h00, 1'b0, 7'h00, 3'h0);
		send(OP_CMP_SKIP_MEM, 8'h5a, 8'h00, 8'h5a, 1'b0, 7'h00, 3'h0);
		send(OP_NIBBLE_EXCHANGE, 8'h00, 8'h00, 8'h3c, 1'b1, 7'h7f, 3'h0);
		send(OP_LOW_BANK_BIT_CLEAR, 8'h00, 8'h00, 8'hff, 1'b1, 7'h7f, 3'h7);
		send(OP_LOW_BANK_BIT_SET, 8'h00, 8'h00, 8'h00, 1'b1, 7'h01, 3'h0);
		send(OP_NONE, 8'h00, 8'h00, 8'h00, 1'b0, 7'h00, 3'h0);
		// Random back-to-back traffic, equality forced half the time
		repeat (200) begin
			a = 8'($random(seed));
			o = ($random(seed) & 1) ? a : 8'($random(seed));
			send(scb_op_type'(3'($unsigned($random(seed)) % 6)), a, o, o, 1'($random(seed)), 7'($random(seed)),
				3'($random(seed)));
		end
		@(negedge mclk_i);
		req_valid_i = 1'b0;
		repeat (3) @(negedge mclk_i);
		check_bit("pending notes", 1'b1, exp_q.size() == 0);
		give_verdict();
	end
endmodule
`default_nettype wire
